// ---- pkg/flash_command_pkg.sv ----
// constants for the flash command unlock front end
package flash_command_pkg;
    // register map (byte addresses)
    localparam logic [11:0] flash_command_reg_offset = 12'hff8;
    // page select sits in its own word so command writes cannot disturb it
    localparam logic [11:0] page_select_offset = 12'hffc;
    localparam logic [7:0] flash_command_reset = 8'h00;
    // command codes
    localparam logic [7:0] cmd_unlock_first = 8'h73;
    localparam logic [7:0] cmd_unlock_second = 8'h8c;
    localparam logic [7:0] cmd_page_erase = 8'h95;
    localparam logic [7:0] cmd_mass_erase = 8'h63;
    localparam logic [7:0] cmd_protect_access = 8'h5e;
    // status field positions
    localparam int status_state_lsb = 0;
    localparam int status_protect_bit = 4;
    localparam int status_page_busy_bit = 5;
    localparam int status_mass_busy_bit = 6;
    localparam int status_debug_bit = 7;
    // axi responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    // lock sequence states, gray along the unlock path
    typedef enum logic [1:0] {
        st_locked = 2'b00,
        st_first = 2'b01,
        st_unlocked = 2'b11
    } lock_state_type;
endpackage

// ---- hdl/flash_command_seq.sv ----
// command sequence checker for the flash command register
`timescale 1ns/10ps
`default_nettype none
module flash_command_seq (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cmd_write,
    input wire logic [7:0] flash_command_field,
    input wire logic from_debug,
    output logic [1:0] lock_state,
    output logic page_erase_start,
    output logic mass_erase_start,
    output logic protect_access
);
    flash_command_pkg::lock_state_type state;
    flash_command_pkg::lock_state_type next_state;
    logic next_page;
    logic next_mass;
    logic next_protect;

    // next sequence state per command write
    always_comb begin
        next_state = state;
        next_page = 1'b0;
        next_mass = 1'b0;
        next_protect = protect_access;
        if (cmd_write) begin
            next_state = flash_command_pkg::st_locked;
            if (flash_command_field == flash_command_pkg::cmd_protect_access) begin
                next_protect = 1'b1;
                next_state = state;
            end else begin
                case (state)
                    flash_command_pkg::st_locked: begin
                        if (flash_command_field == flash_command_pkg::cmd_unlock_first) begin
                            next_state = flash_command_pkg::st_first;
                        end
                    end
                    flash_command_pkg::st_first: begin
                        if (flash_command_field == flash_command_pkg::cmd_unlock_second) begin
                            next_state = flash_command_pkg::st_unlocked;
                        end
                    end
                    flash_command_pkg::st_unlocked: begin
                        // third command consumes the unlock
                        if (flash_command_field == flash_command_pkg::cmd_page_erase) begin
                            next_page = 1'b1;
                        end else if (flash_command_field == flash_command_pkg::cmd_mass_erase) begin
                            next_mass = from_debug;
                        end
                    end
                    default: begin
                        next_state = flash_command_pkg::st_locked;
                    end
                endcase
            end
        end
    end

    // register state, locked after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= flash_command_pkg::st_locked;
            page_erase_start <= 1'b0;
            mass_erase_start <= 1'b0;
            protect_access <= 1'b0;
        end else begin
            state <= next_state;
            page_erase_start <= next_page;
            mass_erase_start <= next_mass;
            protect_access <= next_protect;
        end
    end

    assign lock_state = state;

    AST_SEQ_PAGE: assert property (@(posedge aclk) disable iff (!aresetn)
        page_erase_start |-> $past(state) == flash_command_pkg::st_unlocked)
        else $error("page erase without unlock");
    AST_SEQ_MASS: assert property (@(posedge aclk) disable iff (!aresetn)
        mass_erase_start |-> $past(from_debug) && $past(cmd_write))
        else $error("mass erase not from debug");
endmodule
`default_nettype wire

// ---- hdl/flash_command_unlock.sv ----
// axi4-lite front end for the flash command register and unlock sequence
`timescale 1ns/10ps
`default_nettype none
module flash_command_unlock #(
    parameter int page_width = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic debug_access,
    output logic page_erase_go,
    output logic mass_erase_go,
    output logic [page_width-1:0] erase_page,
    output logic protect_access_en
);
    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [11:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic do_write;
    logic cmd_write;
    logic page_write;
    logic dbg_sync1;
    logic dbg_sync2;
    logic [page_width-1:0] page_select;
    logic [page_width-1:0] next_page_select;
    logic [1:0] lock_state;
    logic page_start;
    logic mass_start;
    logic protect_en;

    // address decode shared by both channels
    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
        is_addr = (a[11:2] == off[11:2]);
    endfunction

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    // low byte lane carries the command
    assign cmd_write = do_write && is_addr(aw_addr, flash_command_pkg::flash_command_reg_offset)
        && w_strb[0];
    assign page_write = do_write && is_addr(aw_addr, flash_command_pkg::page_select_offset) && w_strb[0];

    // hold address and data until both have arrived
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            if (is_addr(aw_addr, flash_command_pkg::flash_command_reg_offset)
                || is_addr(aw_addr, flash_command_pkg::page_select_offset)) begin
                next_bresp = flash_command_pkg::resp_okay;
            end else begin
                next_bresp = flash_command_pkg::resp_slverr;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    // page select register, addresses the page an erase may touch
    always_comb begin
        next_page_select = page_select;
        if (page_write) begin
            next_page_select = w_data[page_width-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= flash_command_pkg::resp_okay;
            page_select <= '0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            page_select <= next_page_select;
        end
    end

    // ready while nothing is held for that channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // ------------------------------------------------------------
    // debug path marker and command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dbg_sync1 <= 1'b0;
            dbg_sync2 <= 1'b0;
        end else begin
            dbg_sync1 <= debug_access;
            dbg_sync2 <= dbg_sync1;
        end
    end

    flash_command_seq seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .cmd_write(cmd_write),
        .flash_command_field(w_data[7:0]),
        .from_debug(dbg_sync2),
        .lock_state(lock_state),
        .page_erase_start(page_start),
        .mass_erase_start(mass_start),
        .protect_access(protect_en)
    );

    // outputs to the erase engine, page captured with the start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_erase_go <= 1'b0;
            mass_erase_go <= 1'b0;
            erase_page <= '0;
            protect_access_en <= 1'b0;
        end else begin
            page_erase_go <= page_start;
            mass_erase_go <= mass_start;
            if (page_start) begin
                erase_page <= page_select;
            end
            protect_access_en <= protect_en;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_rvalid;
    logic [7:0] status;

    // status: state, protect, busy flags, debug
    always_comb begin
        status = 8'h00;
        status[flash_command_pkg::status_state_lsb +: 2] = lock_state;
        status[flash_command_pkg::status_protect_bit] = protect_en;
        status[flash_command_pkg::status_page_busy_bit] = page_erase_go;
        status[flash_command_pkg::status_mass_busy_bit] = mass_erase_go;
        status[flash_command_pkg::status_debug_bit] = dbg_sync2;
    end

    always_comb begin
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_rvalid = s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = flash_command_pkg::resp_okay;
            if (is_addr(s_axi_araddr, flash_command_pkg::flash_command_reg_offset)) begin
                next_rdata = {24'h00_0000, status};
            end else if (is_addr(s_axi_araddr, flash_command_pkg::page_select_offset)) begin
                next_rdata = 32'h0000_0000;
                next_rdata[page_width-1:0] = page_select;
            end else begin
                next_rdata = 32'h0000_0000;
                next_rresp = flash_command_pkg::resp_slverr;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= flash_command_pkg::resp_okay;
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_RESET_LOCKED: assert property (@(posedge aclk)
        !aresetn |=> lock_state == 2'b00 && !page_erase_go)
        else $error("not locked after reset");
    AST_UNLOCK_PAIR: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(lock_state) && lock_state == 2'b11 |-> $past(cmd_write)
        && $past(w_data[7:0]) == flash_command_pkg::cmd_unlock_second)
        else $error("unlock without second code");
    AST_PAGE_GO: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_write && lock_state == 2'b11 && w_data[7:0] == flash_command_pkg::cmd_page_erase
        |-> ##2 page_erase_go)
        else $error("page erase missing");
    AST_PAGE_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
        page_erase_go |-> erase_page == $past(page_select))
        else $error("wrong page erased");
    AST_MASS_GO: assert property (@(posedge aclk) disable iff (!aresetn)
        mass_erase_go |-> $past(lock_state, 2) == 2'b11
        && $past(w_data[7:0], 2) == flash_command_pkg::cmd_mass_erase)
        else $error("mass erase out of sequence");
    AST_MASS_DEBUG: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_write && !dbg_sync2 |-> ##2 !mass_erase_go)
        else $error("mass erase from core");
    AST_PROTECT: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_write && w_data[7:0] == flash_command_pkg::cmd_protect_access |-> ##2 protect_access_en)
        else $error("protect access not enabled");
    AST_RELOCK: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_write && lock_state == 2'b00 && w_data[7:0] != flash_command_pkg::cmd_unlock_first
        && w_data[7:0] != flash_command_pkg::cmd_protect_access |=> lock_state == 2'b00)
        else $error("bad command left unlocked");
    AST_RELOCK_THIRD: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_write && lock_state == 2'b11 && w_data[7:0] != flash_command_pkg::cmd_protect_access
        |=> lock_state == 2'b00)
        else $error("third command left unlocked");
    AST_STATUS_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && is_addr(s_axi_araddr, flash_command_pkg::flash_command_reg_offset)
        |=> s_axi_rvalid && s_axi_rdata[1:0] == $past(lock_state))
        else $error("status read wrong");
    COV_UNLOCK: cover property (@(posedge aclk) disable iff (!aresetn) lock_state == 2'b11);
    COV_PAGE: cover property (@(posedge aclk) disable iff (!aresetn) page_erase_go);
    COV_MASS: cover property (@(posedge aclk) disable iff (!aresetn) mass_erase_go);
    COV_PROTECT: cover property (@(posedge aclk) disable iff (!aresetn) $rose(protect_access_en));
endmodule
`default_nettype wire

// ---- dv/flash_cmd_host.sv ----
// bus master model standing in for the core or the debugger
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_host (
    input wire logic aclk,
    output logic [11:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    output logic bready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    output logic [11:0] araddr,
    output logic arvalid,
    input wire logic arready,
    output logic rready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    // idle bus from time zero
    initial begin
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0000_0000;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    end

    // one write: address and data offered together, each released once taken
    task automatic write_word(input logic [11:0] addr, input logic [31:0] data, output logic [1:0] resp);
        logic aw_open = 1'b1;
        logic w_open = 1'b1;
        @(posedge aclk);
        awaddr <= addr;
        awvalid <= 1'b1;
        wdata <= data;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_open || w_open) begin
            @(posedge aclk);
            if (aw_open && awready === 1'b1) begin
                aw_open = 1'b0;
                awvalid <= 1'b0;
                awaddr <= ~addr; // released payload no longer valid
            end
            if (w_open && wready === 1'b1) begin
                w_open = 1'b0;
                wvalid <= 1'b0;
                wdata <= ~data;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    endtask

    // one read, data and response taken at the rvalid edge
    task automatic read_word(input logic [11:0] addr, output logic [31:0] data, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        araddr <= ~addr;
        do @(posedge aclk); while (rvalid !== 1'b1);
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- dv/flash_command_unlock_bench.sv ----
// self-checking bench for the flash command unlock front end
`timescale 1ns/10ps
`default_nettype none
module flash_command_unlock_bench;
    logic aclk, aresetn, debug_access;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic awvalid, awready, wvalid, wready, bready, bvalid, arvalid, arready, rready, rvalid;
    logic [1:0] bresp, rresp;
    logic page_erase_go, mass_erase_go, protect_access_en;
    logic [3:0] erase_page;
    logic [7:0] last_status;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int page_pulses = 0;
    int mass_pulses = 0;

    flash_command_unlock #(.page_width(4)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .debug_access(debug_access), .page_erase_go(page_erase_go),
        .mass_erase_go(mass_erase_go), .erase_page(erase_page), .protect_access_en(protect_access_en)
    );

    flash_cmd_host i_host (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wvalid(wvalid), .wready(wready), .bready(bready), .bvalid(bvalid), .bresp(bresp),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rready(rready), .rvalid(rvalid),
        .rdata(rdata), .rresp(rresp)
    );

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // pulse counters and hang guard
    always @(posedge aclk) begin
        cycles++;
        if (page_erase_go === 1'b1) page_pulses++;
        if (mass_erase_go === 1'b1) mass_pulses++;
        if (cycles == 4000) begin
            err_count++;
            close_out();
        end
    end

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cmd(input logic [7:0] code, input logic [11:0] addr = 12'hff8);
        logic [1:0] resp;
        i_host.write_word(addr, {24'h00_0000, code}, resp);
        check("write resp", 32'(resp), 32'(flash_command_pkg::resp_okay));
        repeat (4) @(posedge aclk); // go pulse lands one edge after bvalid
    endtask

    task automatic expect_state(input logic [1:0] exp);
        logic [31:0] data;
        logic [1:0] resp;
        i_host.read_word(flash_command_pkg::flash_command_reg_offset, data, resp);
        check("read resp", 32'(resp), 32'(flash_command_pkg::resp_okay));
        check("lock state", 32'(data[1:0]), 32'(exp));
        last_status = data[7:0];
    endtask

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        check("protect", 32'(protect_access_en), 32'h0);
        expect_state(flash_command_pkg::st_locked);
        check("status", 32'(last_status), 32'h0);
        $display("test reset done");
    endtask

    task automatic t_unlock;
        cmd(8'h73);
        expect_state(flash_command_pkg::st_first);
        cmd(8'h8c);
        expect_state(flash_command_pkg::st_unlocked);
        cmd(8'h8c);
        expect_state(flash_command_pkg::st_locked);
        $display("test unlock done");
    endtask

    task automatic t_page;
        int p = page_pulses;
        logic [31:0] data;
        logic [1:0] resp;
        cmd(8'h03, flash_command_pkg::page_select_offset);
        i_host.read_word(flash_command_pkg::page_select_offset, data, resp);
        check("page select", data, 32'h0000_0003);
        cmd(8'h73);
        cmd(8'h8c);
        cmd(8'h95);
        check("page pulses", 32'(page_pulses - p), 32'h1);
        check("erase page", 32'(erase_page), 32'h0000_0003);
        expect_state(flash_command_pkg::st_locked);
        cmd(8'h95);
        check("page pulses", 32'(page_pulses - p), 32'h1);
        $display("test page erase done");
    endtask

    task automatic t_mass;
        int m = mass_pulses;
        for (int dbg = 0; dbg < 2; dbg++) begin
            debug_access <= dbg[0];
            repeat (4) @(posedge aclk);
            cmd(8'h73);
            cmd(8'h8c);
            cmd(8'h63);
            check("mass pulses", 32'(mass_pulses - m), 32'(dbg));
            expect_state(flash_command_pkg::st_locked);
            check("status debug", 32'(last_status[7]), 32'(dbg));
        end
        debug_access <= 1'b0;
        $display("test mass erase done");
    endtask

    task automatic t_bad;
        logic [7:0] first_code [6] = '{8'h8c, 8'h73, 8'h73, 8'h73, 8'h95, 8'h11};
        logic [7:0] second_code [6] = '{8'h8c, 8'h73, 8'h95, 8'h63, 8'h8c, 8'h8c};
        int p = page_pulses;
        for (int i = 0; i < 6; i++) begin
            cmd(first_code[i]);
            cmd(second_code[i]);
            expect_state(flash_command_pkg::st_locked);
        end
        check("page pulses", 32'(page_pulses - p), 32'h0);
        $display("test bad sequence done");
    endtask

    task automatic t_protect;
        cmd(8'h73);
        cmd(8'h5e);
        check("protect", 32'(protect_access_en), 32'h1);
        expect_state(flash_command_pkg::st_first);
        check("status protect", 32'(last_status[4]), 32'h1);
        cmd(8'h8c);
        expect_state(flash_command_pkg::st_unlocked);
        cmd(8'h00);
        expect_state(flash_command_pkg::st_locked);
        $display("test protect done");
    endtask

    task automatic t_map;
        logic [31:0] data;
        logic [1:0] resp;
        i_host.read_word(12'h100, data, resp);
        check("unmapped rresp", 32'(resp), 32'(flash_command_pkg::resp_slverr));
        check("unmapped rdata", data, 32'h0);
        i_host.write_word(12'h100, 32'h0000_0073, resp);
        check("unmapped bresp", 32'(resp), 32'(flash_command_pkg::resp_slverr));
        expect_state(flash_command_pkg::st_locked);
        do_reset();
        check("protect", 32'(protect_access_en), 32'h0);
        expect_state(flash_command_pkg::st_locked);
        $display("test map and reset done");
    endtask

    initial begin
        aresetn = 1'b0;
        debug_access = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_unlock();
        t_page();
        t_mass();
        t_bad();
        t_protect();
        t_map();
        close_out();
    end
endmodule
`default_nettype wire
